// File: stamp_tick_gen.sv
// Shared constants for the address look-up engine and its aging tick divider.
`timescale 1ns/100ps
`default_nettype none

package lookup_pkg;
    // ------------------------------------------------------------------
    // Table geometry
    // ------------------------------------------------------------------
    localparam int TABLE_DEPTH = 1024;
    localparam int ADDR_W = 48;
    localparam int NUM_PORTS = 9;
    localparam int PORT_W = 4;
    localparam int GROUP_BIT = 40;               // I/G bit of the first octet on the wire.
    // ------------------------------------------------------------------
    // Frame length limits (64, 1518, 1522 and 1536 bytes)
    // ------------------------------------------------------------------
    localparam int LEN_W = 11;
    localparam logic [10:0] MIN_FRAME_LEN = 11'h040;
    localparam logic [10:0] MAX_LEN_PLAIN = 11'h5ee;
    localparam logic [10:0] MAX_LEN_VLAN = 11'h5f2;
    localparam logic [10:0] MAX_LEN_LONG = 11'h600;
    // ------------------------------------------------------------------
    // Aging timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ = 64'd25000000;
    localparam longint AGE_PERIOD_S = 64'd300;
    localparam int STAMP_W = 3;
    localparam int AGE_STEPS = 4;                // Stamp ticks that make up one aging period.
    localparam longint TICK_CYCLES = AGE_PERIOD_S * CLK_HZ / AGE_STEPS;
    // ------------------------------------------------------------------
    // Frame engine states
    // ------------------------------------------------------------------
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_LOOK = 1'b1
    } lookup_state_t;
endpackage

module stamp_tick_gen #(
    parameter int unsigned DIV = 32'(lookup_pkg::TICK_CYCLES)
) (
    input wire logic clk_sys,
    input wire logic rst,
    output logic tick
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    // Free running divider; the tick is a one-cycle enable, not a clock.
    always_comb begin
        cnt_next = cnt_reg + 32'h1;
        tick_next = 1'b0;
        if (cnt_reg == 32'(DIV - 1)) begin
            cnt_next = 32'h0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_reg <= 32'h0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule
`default_nettype wire

// File: mac_lookup_engine.sv
// Address look-up, learning, migration, aging and forwarding decision engine.
//
// Contract
// - Fully associative table, 1K 48-bit entries.
// - Any 1K distinct addresses stored, no hashing.
// - New entry only when source address absent.
// - Learn and migrate only on good frames.
// - New entry keeps address, ingress port, stamp.
// - Table full: evict last entry, reuse it.
// - Known address on new port: overwrite port.
// - Known source address seen: refresh stamp.
// - Background scan removes entries older than 300s.
// - Aging switched by pin sampled at reset.
// - Unicast hit: forward to stored port only.
// - Unicast miss: flood all but ingress port.
// - Multicast and broadcast: flood all but ingress.
// - Errored or illegal-size frames are dropped.
// - Pause frames dropped, handed to flow control.
// - Lookup to own ingress port: drop as local.
// - Legal length: 64 bytes up to limit.
`timescale 1ns/100ps
`default_nettype none

module mac_lookup_engine #(
    parameter int DEPTH = lookup_pkg::TABLE_DEPTH,
    parameter int NUM_PORTS = lookup_pkg::NUM_PORTS,
    parameter int unsigned TICK_CYCLES = 32'(lookup_pkg::TICK_CYCLES)
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CFG_AGE_EN,
    input wire logic CFG_LEN_LONG,
    input wire logic FRM_VALID,
    output logic FRM_READY,
    input wire logic [lookup_pkg::ADDR_W-1:0] FRM_SA,
    input wire logic [lookup_pkg::ADDR_W-1:0] FRM_DA,
    input wire logic [lookup_pkg::PORT_W-1:0] FRM_PORT,
    input wire logic [lookup_pkg::LEN_W-1:0] FRM_LEN,
    input wire logic FRM_RX_ERR,
    input wire logic FRM_VLAN,
    input wire logic FRM_PAUSE,
    output logic FWD_VALID,
    output logic [NUM_PORTS-1:0] FWD_MASK,
    output logic [lookup_pkg::PORT_W-1:0] FWD_SRC_PORT,
    output logic PAUSE_VALID,
    output logic [lookup_pkg::PORT_W-1:0] PAUSE_PORT
);
    localparam int IDX_W = $clog2(DEPTH);
    localparam int AW = lookup_pkg::ADDR_W;
    localparam int PW = lookup_pkg::PORT_W;
    localparam int SW = lookup_pkg::STAMP_W;
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);

    // ------------------------------------------------------------------
    // Table storage
    // ------------------------------------------------------------------
    // Every slot is compared in parallel, so any DEPTH distinct addresses fit.
    logic [AW-1:0] addr_mem [DEPTH];
    logic [PW-1:0] port_mem [DEPTH];
    logic [SW-1:0] stamp_mem [DEPTH];
    logic [DEPTH-1:0] valid_reg;
    logic [DEPTH-1:0] valid_next;

    lookup_pkg::lookup_state_t state_reg;
    lookup_pkg::lookup_state_t state_next;
    logic [AW-1:0] sa_reg, sa_next;
    logic [AW-1:0] da_reg, da_next;
    logic [PW-1:0] port_reg, port_next;
    logic [lookup_pkg::LEN_W-1:0] len_reg, len_next;
    logic err_reg, err_next;
    logic vlan_reg, vlan_next;
    logic pause_reg, pause_next;

    logic age_s1_reg, age_s2_reg, len_s1_reg, len_s2_reg;
    logic age_en_reg, age_en_next;
    logic len_long_reg, len_long_next;
    logic [SW-1:0] stamp_now_reg, stamp_now_next;
    logic [IDX_W-1:0] scan_idx_reg, scan_idx_next;
    logic stamp_tick;

    logic fwd_valid_reg, fwd_valid_next;
    logic [NUM_PORTS-1:0] fwd_mask_reg, fwd_mask_next;
    logic [PW-1:0] fwd_src_reg, fwd_src_next;
    logic pause_valid_reg, pause_valid_next;
    logic [PW-1:0] pause_port_reg, pause_port_next;

    logic [IDX_W:0] sa_res, da_res;
    logic sa_hit, da_hit, frm_good, is_group, free_found;
    logic [IDX_W-1:0] sa_idx, da_idx, free_idx;
    logic [PW-1:0] da_port;
    logic [lookup_pkg::LEN_W-1:0] max_len;
    logic wr_en, wr_new, clr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [SW-1:0] scan_age;
    logic in_look;

    default clocking cb_sys @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Parallel search; the lowest matching slot wins, though learning never
    // stores one address twice.
    function automatic logic [IDX_W:0] find_addr(input logic [AW-1:0] a);
        logic [IDX_W:0] r;
        r = '0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (valid_reg[i] && addr_mem[i] == a) begin
                r = {1'b1, IDX_W'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [NUM_PORTS-1:0] port_bit(input logic [PW-1:0] p);
        return NUM_PORTS'(1) << p;
    endfunction

    function automatic logic [NUM_PORTS-1:0] all_but(input logic [PW-1:0] p);
        return ~port_bit(p);
    endfunction

    // ------------------------------------------------------------------
    // Strap sampling and aging time base
    // ------------------------------------------------------------------
    stamp_tick_gen #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .clk_sys(CLK_SYS),
        .rst(RST),
        .tick(stamp_tick)
    );

    // Straps are tracked while reset is asserted and held after it; the last synchronised value wins.
    always_comb begin
        age_en_next = RST ? age_s2_reg : age_en_reg;
        len_long_next = RST ? len_s2_reg : len_long_reg;
        stamp_now_next = stamp_tick ? SW'(stamp_now_reg + SW'(1)) : stamp_now_reg;
    end

    always_ff @(posedge CLK_SYS) begin
        age_s1_reg <= CFG_AGE_EN;
        age_s2_reg <= age_s1_reg;
        len_s1_reg <= CFG_LEN_LONG;
        len_s2_reg <= len_s1_reg;
        age_en_reg <= age_en_next;
        len_long_reg <= len_long_next;
        if (RST) begin
            stamp_now_reg <= '0;
        end else begin
            stamp_now_reg <= stamp_now_next;
        end
    end

    // ------------------------------------------------------------------
    // Frame request capture
    // ------------------------------------------------------------------
    // A frame is taken in IDLE and resolved in LOOK, so the next one waits.
    assign in_look = (state_reg == lookup_pkg::ST_LOOK);
    assign FRM_READY = !RST && (state_reg == lookup_pkg::ST_IDLE);

    always_comb begin
        state_next = lookup_pkg::ST_IDLE;
        sa_next = sa_reg;
        da_next = da_reg;
        port_next = port_reg;
        len_next = len_reg;
        err_next = err_reg;
        vlan_next = vlan_reg;
        pause_next = pause_reg;
        if (FRM_VALID && FRM_READY) begin
            state_next = lookup_pkg::ST_LOOK;
            sa_next = FRM_SA;
            da_next = FRM_DA;
            port_next = FRM_PORT;
            len_next = FRM_LEN;
            err_next = FRM_RX_ERR;
            vlan_next = FRM_VLAN;
            pause_next = FRM_PAUSE;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_reg <= lookup_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
        sa_reg <= sa_next;
        da_reg <= da_next;
        port_reg <= port_next;
        len_reg <= len_next;
        err_reg <= err_next;
        vlan_reg <= vlan_next;
        pause_reg <= pause_next;
    end

    // ------------------------------------------------------------------
    // Lookup and frame qualification
    // ------------------------------------------------------------------
    always_comb begin
        sa_res = find_addr(sa_reg);
        da_res = find_addr(da_reg);
        sa_hit = sa_res[IDX_W];
        sa_idx = sa_res[IDX_W-1:0];
        da_hit = da_res[IDX_W];
        da_idx = da_res[IDX_W-1:0];
        da_port = port_mem[da_idx];
        is_group = da_reg[lookup_pkg::GROUP_BIT];
        free_found = 1'b0;
        free_idx = '0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (!valid_reg[i]) begin
                free_found = 1'b1;
                free_idx = IDX_W'(i);
            end
        end
        // The long limit covers tagged frames too; the short limits depend on the tag.
        if (len_long_reg) begin
            max_len = lookup_pkg::MAX_LEN_LONG;
        end else if (vlan_reg) begin
            max_len = lookup_pkg::MAX_LEN_VLAN;
        end else begin
            max_len = lookup_pkg::MAX_LEN_PLAIN;
        end
        frm_good = !err_reg && len_reg >= lookup_pkg::MIN_FRAME_LEN && len_reg <= max_len;
    end

    // ------------------------------------------------------------------
    // Forwarding decision
    // ------------------------------------------------------------------
    always_comb begin
        fwd_valid_next = in_look;
        fwd_src_next = in_look ? port_reg : fwd_src_reg;
        pause_valid_next = in_look && frm_good && pause_reg;
        pause_port_next = pause_valid_next ? port_reg : pause_port_reg;
        fwd_mask_next = '0;
        if (!in_look) begin
            fwd_mask_next = fwd_mask_reg;
        end else if (!frm_good || pause_reg) begin
            fwd_mask_next = '0;
        end else if (is_group) begin
            fwd_mask_next = all_but(port_reg);
        end else if (da_hit && da_port == port_reg) begin
            fwd_mask_next = '0;
        end else if (da_hit) begin
            fwd_mask_next = port_bit(da_port);
        end else begin
            fwd_mask_next = all_but(port_reg);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            fwd_valid_reg <= 1'b0;
            fwd_mask_reg <= '0;
            fwd_src_reg <= '0;
            pause_valid_reg <= 1'b0;
            pause_port_reg <= '0;
        end else begin
            fwd_valid_reg <= fwd_valid_next;
            fwd_mask_reg <= fwd_mask_next;
            fwd_src_reg <= fwd_src_next;
            pause_valid_reg <= pause_valid_next;
            pause_port_reg <= pause_port_next;
        end
    end

    assign FWD_VALID = fwd_valid_reg;
    assign FWD_MASK = fwd_mask_reg;
    assign FWD_SRC_PORT = fwd_src_reg;
    assign PAUSE_VALID = pause_valid_reg;
    assign PAUSE_PORT = pause_port_reg;

    // ------------------------------------------------------------------
    // Learning, migration, refresh and aging scan
    // ------------------------------------------------------------------
    // Frame writes happen only in LOOK and scan removals only in IDLE, so the
    // two never touch the table in the same cycle.
    always_comb begin
        wr_en = in_look && frm_good;
        wr_new = wr_en && !sa_hit;
        wr_idx = sa_idx;
        if (wr_new) begin
            wr_idx = free_found ? free_idx : LAST_IDX;
        end
        scan_age = SW'(stamp_now_reg - stamp_mem[scan_idx_reg]);
        scan_idx_next = scan_idx_reg;
        clr_en = 1'b0;
        if (!RST && !in_look) begin
            scan_idx_next = IDX_W'(scan_idx_reg + IDX_W'(1));
            clr_en = age_en_reg && valid_reg[scan_idx_reg]
                && scan_age >= SW'(lookup_pkg::AGE_STEPS);
        end
        valid_next = valid_reg;
        if (wr_en) begin
            valid_next[wr_idx] = 1'b1;
        end
        if (clr_en) begin
            valid_next[scan_idx_reg] = 1'b0;
        end
    end

    // Storage is not reset; only the valid bits are, which is all that matters.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            valid_reg <= '0;
            scan_idx_reg <= '0;
        end else begin
            valid_reg <= valid_next;
            scan_idx_reg <= scan_idx_next;
        end
        if (wr_en) begin
            addr_mem[wr_idx] <= sa_reg;
            port_mem[wr_idx] <= port_reg;
            stamp_mem[wr_idx] <= stamp_now_reg;
        end
    end

    // ------------------------------------------------------------------
    // Checks and coverage
    // ------------------------------------------------------------------
    a_bad_frame_drop: assert property (in_look && !frm_good |=> FWD_VALID && FWD_MASK == '0)
        else $error("Errored frame was forwarded.");
    a_pause_consumed: assert property (in_look && frm_good && pause_reg
        |=> PAUSE_VALID && FWD_MASK == '0 && PAUSE_PORT == $past(port_reg))
        else $error("Pause frame not consumed.");
    a_group_flood: assert property (in_look && frm_good && !pause_reg && is_group
        |=> FWD_MASK == all_but($past(port_reg)))
        else $error("Group frame not flooded.");
    a_miss_flood: assert property (in_look && frm_good && !pause_reg && !is_group && !da_hit
        |=> FWD_MASK == all_but($past(port_reg)))
        else $error("Unknown unicast not flooded.");
    a_hit_single_port: assert property (in_look && frm_good && !pause_reg && !is_group && da_hit
        && da_port != port_reg |=> FWD_MASK == port_bit($past(da_port)))
        else $error("Known unicast sent to wrong ports.");
    a_local_drop: assert property (in_look && frm_good && !pause_reg && !is_group && da_hit
        && da_port == port_reg |=> FWD_MASK == '0)
        else $error("Local frame was forwarded.");
    a_learn_stores: assert property (wr_new |=> valid_reg[$past(wr_idx)]
        && addr_mem[$past(wr_idx)] == $past(sa_reg)
        && stamp_mem[$past(wr_idx)] == $past(stamp_now_reg))
        else $error("Learned entry content wrong.");
    a_learn_guard: assert property (in_look && !frm_good |=> valid_reg == $past(valid_reg))
        else $error("Table written by a bad frame.");
    a_evict_last: assert property (wr_new && (&valid_reg) |=> addr_mem[LAST_IDX]
        == $past(sa_reg)) else $error("Full table did not reuse the last slot.");
    a_migrate_port: assert property (in_look && frm_good && sa_hit && port_mem[sa_idx] != port_reg
        |=> port_mem[$past(sa_idx)] == $past(port_reg))
        else $error("Moved station port not updated.");
    a_aging_off: assert property (!age_en_reg |=> ($past(valid_reg) & ~valid_reg) == '0)
        else $error("Entry aged out while aging disabled.");
    a_one_per_frame: assert property (FRM_VALID && FRM_READY
        |=> !FRM_READY && !FWD_VALID ##1 FWD_VALID && FRM_READY)
        else $error("Frame not resolved in two cycles.");
    a_scan_moves: assert property (!in_look |=> scan_idx_reg == IDX_W'($past(scan_idx_reg) + 1))
        else $error("Aging scan stalled in idle.");

    c_learn_new: cover property (wr_new && free_found);
    c_evict: cover property (wr_new && !free_found);
    c_migrate: cover property (in_look && frm_good && sa_hit && port_mem[sa_idx] != port_reg);
    c_age_out: cover property (clr_en);
endmodule
`default_nettype wire

// File: frame_port_model.sv
// Far-side model: port receive paths that offer frames and forwarding queues that take results.
`timescale 1ns/100ps
`default_nettype none

module frame_port_model (
    input wire logic clk,
    input wire logic frm_ready,
    output logic frm_valid,
    output logic [47:0] frm_sa,
    output logic [47:0] frm_da,
    output logic [3:0] frm_port,
    output logic [10:0] frm_len,
    output logic frm_rx_err,
    output logic frm_vlan,
    output logic frm_pause,
    input wire logic fwd_valid,
    input wire logic [8:0] fwd_mask,
    input wire logic [3:0] fwd_src_port,
    input wire logic pause_valid,
    input wire logic [3:0] pause_port
);
    logic [17:0] results[$];
    int stalls = 0;

    // ------------------------------------------------------------------
    // Request side
    // ------------------------------------------------------------------
    // Nothing is offered until the first task call.
    initial begin
        frm_valid = 1'b0;
        {frm_sa, frm_da, frm_port, frm_len, frm_rx_err, frm_vlan, frm_pause} = '0;
    end

    // A frame is raised after a falling edge and held until a rising edge sees ready high.
    // Ready is judged at the falling edge, where it has long settled.
    task automatic send(input logic [47:0] sa, input logic [47:0] da, input logic [3:0] port,
                        input logic [10:0] len, input logic [2:0] flags);
        int n;
        n = 0;
        @(negedge clk);
        {frm_rx_err, frm_vlan, frm_pause} = flags;
        frm_sa = sa;
        frm_da = da;
        frm_port = port;
        frm_len = len;
        frm_valid = 1'b1;
        while (frm_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (frm_ready !== 1'b1) begin
            stalls++;
        end
        @(posedge clk);
    endtask

    // Released fields are inverted so that a stale value can never pass for a held one.
    task automatic release_bus();
        @(negedge clk);
        frm_valid = 1'b0;
        {frm_sa, frm_da, frm_port, frm_len} = ~{frm_sa, frm_da, frm_port, frm_len};
        {frm_rx_err, frm_vlan, frm_pause} = ~{frm_rx_err, frm_vlan, frm_pause};
    endtask

    // ------------------------------------------------------------------
    // Result side
    // ------------------------------------------------------------------
    // The queues have no back-pressure, so each one-cycle result is taken at its closing edge.
    always @(posedge clk) begin
        if (fwd_valid === 1'b1) begin
            results.push_back({pause_valid, pause_valid ? pause_port : 4'h0, fwd_src_port,
                               fwd_mask});
        end
    end
endmodule

`default_nettype wire

// File: mac_lookup_engine_tb_top.sv
// Self-checking testbench of the address look-up and forwarding engine.
`timescale 1ns/100ps
`default_nettype none

module mac_lookup_engine_tb_top;
    localparam logic [8:0] ALL = 9'h1ff;
    localparam logic [47:0] BCAST = 48'hffff_ffff_ffff;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cfg_age_en = 1'b1;
    logic cfg_len_long = 1'b1;
    logic frm_valid, frm_ready, frm_rx_err, frm_vlan, frm_pause;
    logic [47:0] frm_sa, frm_da;
    logic [3:0] frm_port, fwd_src_port, pause_port;
    logic [10:0] frm_len;
    logic fwd_valid, pause_valid;
    logic [8:0] fwd_mask;
    int num_errors = 0;
    int samples_checked = 0;

    // ------------------------------------------------------------------
    // Clock, design and far side
    // ------------------------------------------------------------------
    // A 16-entry table and 16-cycle stamp ticks keep the fill and aging runs short.
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    mac_lookup_engine #(.DEPTH(16), .NUM_PORTS(9), .TICK_CYCLES(16)) uut (
        .CLK_SYS(clk_sys), .RST(rst), .CFG_AGE_EN(cfg_age_en), .CFG_LEN_LONG(cfg_len_long),
        .FRM_VALID(frm_valid), .FRM_READY(frm_ready), .FRM_SA(frm_sa), .FRM_DA(frm_da),
        .FRM_PORT(frm_port), .FRM_LEN(frm_len), .FRM_RX_ERR(frm_rx_err), .FRM_VLAN(frm_vlan),
        .FRM_PAUSE(frm_pause), .FWD_VALID(fwd_valid), .FWD_MASK(fwd_mask),
        .FWD_SRC_PORT(fwd_src_port), .PAUSE_VALID(pause_valid), .PAUSE_PORT(pause_port));

    frame_port_model port_model (
        .clk(clk_sys), .frm_ready(frm_ready), .frm_valid(frm_valid), .frm_sa(frm_sa),
        .frm_da(frm_da), .frm_port(frm_port), .frm_len(frm_len), .frm_rx_err(frm_rx_err),
        .frm_vlan(frm_vlan), .frm_pause(frm_pause), .fwd_valid(fwd_valid),
        .fwd_mask(fwd_mask), .fwd_src_port(fwd_src_port), .pause_valid(pause_valid),
        .pause_port(pause_port));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Unicast, locally administered station addresses.
    function automatic logic [47:0] ad(input int k);
        return 48'h0200_0000_0000 | 48'(k);
    endfunction

    // Flood mask: every port but the ingress one.
    function automatic logic [8:0] fl(input int p);
        return ALL & ~(9'h001 << p);
    endfunction

    task automatic tx(input logic [47:0] sa, input logic [47:0] da, input int p,
                      input int len = 64, input logic [2:0] f = 3'b000);
        port_model.send(sa, da, 4'(p), 11'(len), f);
    endtask

    task automatic check_val(input string what, input logic [19:0] exp, input logic [19:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Results come back in order, so each expectation pops the oldest one.
    task automatic expect_res(input logic [8:0] mask, input int src, input logic pv);
        int n;
        n = 0;
        while (port_model.results.size() == 0 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        if (port_model.results.size() == 0) begin
            num_errors++;
            $display("Error result expected present seen none");
            tally_and_finish();
        end else begin
            check_val("result", {2'b00, pv, pv ? 4'(src) : 4'h0, 4'(src), mask},
                      {2'b00, port_model.results.pop_front()});
        end
    endtask

    task automatic do_reset(input logic age, input logic long_len);
        @(negedge clk_sys);
        rst = 1'b1;
        cfg_age_en = age;
        cfg_len_long = long_len;
        repeat (12) @(negedge clk_sys);
        check_val("outputs in reset", 20'h0, {frm_ready, fwd_valid, pause_valid, pause_port,
                  fwd_src_port, fwd_mask});
        rst = 1'b0;
        port_model.results.delete();
        @(negedge clk_sys);
        check_val("ready after reset", 20'h1, {19'h0, frm_ready});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Back-to-back frames: miss, hit, migration and a local destination.
    task automatic sc_learn_forward();
        tx(ad(1), ad(2), 1);
        tx(ad(2), ad(1), 3);
        tx(ad(1), ad(2), 4);
        tx(ad(3), ad(1), 0);
        tx(ad(3), ad(1), 4);
        port_model.release_bus();
        expect_res(fl(1), 1, 1'b0);
        expect_res(9'h002, 3, 1'b0);
        expect_res(9'h008, 4, 1'b0);
        expect_res(9'h010, 0, 1'b0);
        expect_res(9'h000, 4, 1'b0);
    endtask

    // Bad, short and long frames are dropped and learn nothing; a pause frame is dropped but learns; group frames flood.
    task automatic sc_drop();
        tx(ad(5), ad(1), 6, 64, 3'b100);
        tx(ad(6), ad(1), 7, 63);
        tx(ad(7), ad(1), 7, 1537);
        tx(ad(8), ad(1), 2, 64, 3'b001);
        tx(ad(9), 48'h0100_5e00_0001, 5);
        tx(ad(10), BCAST, 8, 1536);
        for (int k = 5; k < 9; k++) begin
            tx(ad(11), ad(k), 0);
        end
        port_model.release_bus();
        expect_res(9'h000, 6, 1'b0);
        expect_res(9'h000, 7, 1'b0);
        expect_res(9'h000, 7, 1'b0);
        expect_res(9'h000, 2, 1'b1);
        expect_res(fl(5), 5, 1'b0);
        expect_res(fl(8), 8, 1'b0);
        expect_res(fl(0), 0, 1'b0);
        expect_res(fl(0), 0, 1'b0);
        expect_res(fl(0), 0, 1'b0);
        expect_res(9'h004, 0, 1'b0);
    endtask

    // With aging on, an idle entry is gone well inside two aging periods.
    task automatic sc_aging();
        tx(ad(12), BCAST, 2);
        port_model.release_bus();
        repeat (90) @(negedge clk_sys);
        tx(ad(13), ad(12), 5);
        port_model.release_bus();
        expect_res(fl(2), 2, 1'b0);
        expect_res(fl(5), 5, 1'b0);
    endtask

    // Aging off and short limits: fill the table, check every entry but the first, then evict the last.
    task automatic sc_fill_evict();
        for (int k = 0; k < 16; k++) begin
            tx(ad(16 + k), BCAST, k % 8 + 1);
        end
        tx(ad(16), ad(17), 1, 1518);
        tx(ad(16), ad(17), 1, 1519);
        tx(ad(16), ad(17), 1, 1522, 3'b010);
        tx(ad(16), ad(17), 1, 1523, 3'b010);
        port_model.release_bus();
        for (int k = 0; k < 16; k++) begin
            expect_res(fl(k % 8 + 1), k % 8 + 1, 1'b0);
        end
        expect_res(9'h004, 1, 1'b0);
        expect_res(9'h000, 1, 1'b0);
        expect_res(9'h004, 1, 1'b0);
        expect_res(9'h000, 1, 1'b0);
        repeat (90) @(negedge clk_sys);
        for (int k = 1; k < 16; k++) begin
            tx(ad(16), ad(16 + k), 1);
        end
        tx(ad(32), BCAST, 3);
        tx(ad(16), ad(31), 1);
        tx(ad(16), ad(32), 1);
        tx(ad(16), ad(30), 1);
        port_model.release_bus();
        for (int k = 1; k < 16; k++) begin
            expect_res((k % 8 == 0) ? 9'h000 : 9'h001 << (k % 8 + 1), 1, 1'b0);
        end
        expect_res(fl(3), 3, 1'b0);
        expect_res(fl(1), 1, 1'b0);
        expect_res(9'h008, 1, 1'b0);
        expect_res(9'h080, 1, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and verdict
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // The second reset lands mid-run, after traffic, with both straps changed.
    initial begin
        do_reset(1'b1, 1'b1);
        sc_learn_forward();
        sc_drop();
        sc_aging();
        do_reset(1'b0, 1'b0);
        sc_fill_evict();
        check_val("stalled requests", 20'h0, 20'(port_model.stalls));
        tally_and_finish();
    end
endmodule

`default_nettype wire
